// File: src/counter_array_regs.svh
// What this block does
// [RULE1] eight event flags can request the interrupt
// [RULE2] main flag sets on 16-bit counter wrap
// [RULE3] cycle flag sets on carry from bit N
// [RULE4] flags set regardless of interrupt enables
// [RULE5] each flag gated by its own enable
// [RULE6] processor needs global and array enables set
// [RULE7] six channels run independently in own mode
// [RULE8] one shared cycle length for N-bit PWM
// [RULE9] mode bits 5/4 pick rise/fall capture
// [RULE10] 8-bit PWM when length select is 00
// [RULE11] mode bit 7 selects 16-bit PWM
// [RULE12] comparator off: toggle holds, PWM drives low
// [RULE13] reload view bit routes byte accesses
// [RULE14] match with match-flag enable sets event flag
// [RULE15] cycle enable gates the bit-N overflow
// [RULE16] capture edge copies counter into compare
// [RULE17] capture sets channel flag, may interrupt
// [RULE18] only software clears event flags
// [RULE19] synchronised pin level stays readable
// [RULE20] pin levels must last two clocks
// [RULE21] software timer flags on 16-bit equality
// [RULE22] low byte write clears, high sets comparator
// [RULE23] counter wraps FFFF to 0000, sets flag
// [RULE24] length select sets N for PWM, overflow
// [RULE25] interrupt is OR of enabled flags
`ifndef COUNTER_ARRAY_REGS_SVH
`define COUNTER_ARRAY_REGS_SVH

// register offsets
`define CCA_CTRL_ADDR   8'h00
`define CCA_FLAGS_ADDR  8'h04
`define CCA_PWMCFG_ADDR 8'h08
`define CCA_COUNT_ADDR  8'h0C
`define CCA_CH_BASE     8'h20
`define CCA_SUB_MODE    2'h0
`define CCA_SUB_LOW     2'h1
`define CCA_SUB_HIGH    2'h2

// field positions
`define CCA_CTRL_RUN    0
`define CCA_CTRL_MAINEN 1
`define CCA_FLAG_MAIN   6
`define CCA_FLAG_CYCLE  7
`define CCA_FLAG_PIN    8
`define CCA_PWM_COVEN   6
`define CCA_PWM_RELOAD_VIEW_SEL   7

// reset values and counts
`define CCA_MODE_RESET  8'h00
`define CCA_CNT_MAX     16'hFFFF
`define CCA_N_BASE      16'h0100

`endif

// File: src/counter_array_pkg.sv
package counter_array_pkg;

    typedef struct packed {
        logic wide;
        logic comp;
        logic rise;
        logic fall;
        logic mflag;
        logic toggle;
        logic pulse;
        logic irq_en;
    } chan_mode_t;

    typedef enum logic [2:0] {
        CK_OFF     = 3'h0,
        CK_CAPTURE = 3'h1,
        CK_TIMER   = 3'h3,
        CK_HSO     = 3'h2,
        CK_FREQ    = 3'h6,
        CK_PULSE_MOD_EN    = 3'h7,
        CK_PWM16   = 3'h5
    } chan_kind_t;

    typedef struct packed {
        chan_mode_t  mode;
        logic [15:0] cmp;
        logic [15:0] rld;
        logic        out;
        logic        oe;
        logic        s1;
        logic        sync;
        logic        prev;
    } chan_t;

    typedef struct packed {
        chan_t [5:0] ch;
        logic [15:0] cnt;
        logic        run;
        logic        main_en;
        logic        cov_en;
        logic        reload_view_sel;
        logic [1:0]  cls;
        logic [7:0]  flags;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        irq;
    } state_t;

endpackage

// File: src/counter_array_capture_compare.sv
`timescale 1ns/1ps
`include "counter_array_regs.svh"
module counter_array_capture_compare
    import counter_array_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // channel pins
    input  wire logic [5:0]  CHANNEL_PIN_IN,
    output logic      [5:0]  CHANNEL_PIN_OUT,
    output logic      [5:0]  CHANNEL_PIN_OE,
    // interrupt request
    output logic             IRQ
);

    state_t      st;
    state_t      next_st;
    logic [5:0]  eq16;
    logic [5:0]  eq_n;
    logic [5:0]  eq_low8;
    logic [5:0]  edge_hit;
    logic [15:0] nmask;
    logic        carry_n;
    logic        main_carry;
    logic        setup;
    logic        wr;
    logic        hit_ch;
    logic [2:0]  ci;
    logic [7:0]  set;
    logic [7:0]  clr;
    logic [7:0]  en_vec;
    logic [15:0] view;
    logic        use_rld;
    chan_kind_t  k;

    function automatic chan_kind_t kind_of(input chan_mode_t m);
        if (m.pulse && m.wide)
            kind_of = CK_PWM16;                                  // [RULE11]
        else if (m.pulse && !m.toggle)
            kind_of = CK_PULSE_MOD_EN;                                   // [RULE10]
        else if (m.pulse)
            kind_of = CK_FREQ;
        else if (m.toggle)
            kind_of = CK_HSO;
        else if ((m.rise || m.fall) && !m.mflag)
            kind_of = CK_CAPTURE;                                // [RULE9]
        else if (m.mflag || m.comp)
            kind_of = CK_TIMER;
        else
            kind_of = CK_OFF;
    endfunction

    // N-bit mask from the shared length select
    assign nmask      = 16'((`CCA_N_BASE << st.cls) - 16'h1);    // [RULE24] [RULE8]
    assign carry_n    = st.run && ((st.cnt & nmask) == nmask);   // [RULE3]
    assign main_carry = st.run && (st.cnt == `CCA_CNT_MAX);      // [RULE2]
    assign setup      = PSEL && !PENABLE;
    assign wr         = PSEL && PENABLE && st.ready && PWRITE && !st.slverr;

    // per-channel comparators and edge detect
    for (genvar i = 0; i < 6; i++) begin : g_ch
        assign eq16[i]    = st.run && (st.cnt == st.ch[i].cmp);
        assign eq_low8[i] = st.run && (st.cnt[7:0] == st.ch[i].cmp[7:0]);
        assign eq_n[i]    = st.run && ((st.cnt & nmask) == (st.ch[i].cmp & nmask));
        assign edge_hit[i] = (st.ch[i].mode.rise && st.ch[i].sync && !st.ch[i].prev)
                          || (st.ch[i].mode.fall && !st.ch[i].sync && st.ch[i].prev);
        assign en_vec[i]  = st.ch[i].mode.irq_en;
    end
    assign en_vec[`CCA_FLAG_MAIN]  = st.main_en;
    assign en_vec[`CCA_FLAG_CYCLE] = st.cov_en;

    always_comb begin
        next_st = st;
        next_st.ready = 1'b0;
        next_st.slverr = 1'b0;
        set = 8'h00;
        clr = 8'h00;
        k = CK_OFF;
        hit_ch = !PADDR[7] && (PADDR[6:4] >= 3'd2) && (PADDR[3:2] != 2'd3)
              && (PADDR[1:0] == 2'd0);
        // keep the channel index in range for non-channel addresses
        ci = hit_ch ? 3'(PADDR[6:4] - 3'd2) : 3'd0;
        use_rld = st.reload_view_sel && (st.cls != 2'd0)
               && (kind_of(st.ch[ci].mode) == CK_PULSE_MOD_EN);          // [RULE13]
        view = use_rld ? st.ch[ci].rld : st.ch[ci].cmp;

        // counter
        if (st.run)
            next_st.cnt = st.cnt + 16'h1;                        // [RULE23]

        // channels
        for (int i = 0; i < 6; i++) begin
            k = kind_of(st.ch[i].mode);                          // [RULE7]
            next_st.ch[i].s1 = CHANNEL_PIN_IN[i];
            next_st.ch[i].sync = st.ch[i].s1;
            next_st.ch[i].prev = st.ch[i].sync;
            next_st.ch[i].oe = (k == CK_HSO) || (k == CK_FREQ)
                            || (k == CK_PULSE_MOD_EN) || (k == CK_PWM16);
            case (k)
                CK_CAPTURE: begin
                    if (edge_hit[i]) begin
                        next_st.ch[i].cmp = st.cnt;              // [RULE16]
                        set[i] = 1'b1;                           // [RULE17]
                    end
                end
                CK_TIMER: begin
                    if (st.ch[i].mode.comp && st.ch[i].mode.mflag && eq16[i])
                        set[i] = 1'b1;                           // [RULE21]
                end
                CK_HSO: begin
                    if (st.ch[i].mode.comp && eq16[i]) begin     // [RULE12]
                        next_st.ch[i].out = !st.ch[i].out;
                        set[i] = st.ch[i].mode.mflag;            // [RULE14]
                    end
                end
                CK_FREQ: begin
                    if (st.ch[i].mode.comp && eq_low8[i]) begin  // [RULE12]
                        next_st.ch[i].out = !st.ch[i].out;
                        next_st.ch[i].cmp[7:0] = st.ch[i].cmp[7:0] + st.ch[i].cmp[15:8];
                    end
                    if (st.ch[i].mode.comp && st.ch[i].mode.mflag && eq16[i])
                        set[i] = 1'b1;                           // [RULE14]
                end
                CK_PULSE_MOD_EN: begin
                    if (!st.ch[i].mode.comp) begin
                        next_st.ch[i].out = 1'b0;                // [RULE12]
                    end else if (carry_n) begin
                        next_st.ch[i].out = 1'b0;
                        if (st.cls == 2'd0)
                            next_st.ch[i].cmp[7:0] = st.ch[i].cmp[15:8]; // [RULE10]
                        else
                            next_st.ch[i].cmp = st.ch[i].rld;    // [RULE24]
                    end else if (eq_n[i]) begin
                        next_st.ch[i].out = 1'b1;
                        set[i] = st.ch[i].mode.mflag;            // [RULE14]
                    end
                end
                CK_PWM16: begin
                    if (!st.ch[i].mode.comp || main_carry) begin
                        next_st.ch[i].out = 1'b0;                // [RULE12] [RULE11]
                    end else if (eq16[i]) begin
                        next_st.ch[i].out = 1'b1;
                        set[i] = st.ch[i].mode.mflag;            // [RULE14]
                    end
                end
                default: begin
                end
            endcase
        end
        set[`CCA_FLAG_MAIN] = main_carry;                        // [RULE2] [RULE4]
        set[`CCA_FLAG_CYCLE] = carry_n;                          // [RULE3] [RULE4]

        // apb setup: latch answer for the access phase
        if (setup) begin
            next_st.ready = 1'b1;
            next_st.rdata = 32'h0;
            case (PADDR)
                `CCA_CTRL_ADDR: begin
                    next_st.rdata[`CCA_CTRL_RUN] = st.run;
                    next_st.rdata[`CCA_CTRL_MAINEN] = st.main_en;
                end
                `CCA_FLAGS_ADDR: begin
                    next_st.rdata[7:0] = st.flags;
                    for (int i = 0; i < 6; i++)
                        next_st.rdata[`CCA_FLAG_PIN + i] = st.ch[i].sync; // [RULE19]
                end
                `CCA_PWMCFG_ADDR: begin
                    next_st.rdata[1:0] = st.cls;
                    next_st.rdata[`CCA_PWM_COVEN] = st.cov_en;
                    next_st.rdata[`CCA_PWM_RELOAD_VIEW_SEL] = st.reload_view_sel;
                end
                `CCA_COUNT_ADDR: next_st.rdata[15:0] = st.cnt;
                default: begin
                    if (!hit_ch)
                        next_st.slverr = 1'b1;
                    else if (PADDR[3:2] == `CCA_SUB_MODE)
                        next_st.rdata[7:0] = st.ch[ci].mode;
                    else if (PADDR[3:2] == `CCA_SUB_LOW)
                        next_st.rdata[7:0] = view[7:0];
                    else
                        next_st.rdata[7:0] = view[15:8];
                end
            endcase
        end

        // apb write in the access phase
        if (wr) begin
            case (PADDR)
                `CCA_CTRL_ADDR: begin
                    next_st.run = PWDATA[`CCA_CTRL_RUN];
                    next_st.main_en = PWDATA[`CCA_CTRL_MAINEN];
                end
                `CCA_FLAGS_ADDR: clr = PWDATA[7:0];              // [RULE18]
                `CCA_PWMCFG_ADDR: begin
                    next_st.cls = PWDATA[1:0];                   // [RULE8]
                    next_st.cov_en = PWDATA[`CCA_PWM_COVEN];
                    next_st.reload_view_sel = PWDATA[`CCA_PWM_RELOAD_VIEW_SEL];
                end
                `CCA_COUNT_ADDR: next_st.cnt = PWDATA[15:0];
                default: begin
                    if (PADDR[3:2] == `CCA_SUB_MODE) begin
                        next_st.ch[ci].mode = PWDATA[7:0];
                    end else if (PADDR[3:2] == `CCA_SUB_LOW) begin
                        if (use_rld)
                            next_st.ch[ci].rld[7:0] = PWDATA[7:0]; // [RULE13]
                        else
                            next_st.ch[ci].cmp[7:0] = PWDATA[7:0];
                        next_st.ch[ci].mode.comp = 1'b0;         // [RULE22]
                    end else begin
                        if (use_rld)
                            next_st.ch[ci].rld[15:8] = PWDATA[7:0]; // [RULE13]
                        else
                            next_st.ch[ci].cmp[15:8] = PWDATA[7:0];
                        next_st.ch[ci].mode.comp = 1'b1;         // [RULE22]
                    end
                end
            endcase
        end

        // sticky flags, set wins over clear
        next_st.flags = (st.flags & ~clr) | set;                 // [RULE1] [RULE18]
        next_st.irq = 1'b0;
        for (int i = 0; i < 6; i++)
            next_st.irq = next_st.irq
                       || (next_st.flags[i] && next_st.ch[i].mode.irq_en); // [RULE5]
        next_st.irq = next_st.irq
                   || (next_st.flags[`CCA_FLAG_MAIN] && next_st.main_en)
                   || (next_st.flags[`CCA_FLAG_CYCLE] && next_st.cov_en); // [RULE15] [RULE25]
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N)
            st <= '0;
        else
            st <= next_st;
    end

    assign PRDATA          = st.rdata;
    assign PREADY          = st.ready;
    assign PSLVERR         = st.slverr;
    assign IRQ             = st.irq;
    for (genvar i = 0; i < 6; i++) begin : g_pin
        assign CHANNEL_PIN_OUT[i] = st.ch[i].out;
        assign CHANNEL_PIN_OE[i]  = st.ch[i].oe;
    end

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    logic wr_now;
    assign wr_now = PSEL && PENABLE && PREADY && PWRITE;

    sequence s_low_write;
        wr_now && (PADDR == (`CCA_CH_BASE + 8'h14));
    endsequence
    sequence s_high_write;
        wr_now && (PADDR == (`CCA_CH_BASE + 8'h18));
    endsequence
    sequence s_wrap;
        main_carry && !(wr_now && (PADDR == `CCA_COUNT_ADDR));
    endsequence

    property p_irq_tree;
        IRQ == (|(st.flags & en_vec));
    endproperty
    a_irq_tree: assert property (p_irq_tree) else $error("irq not or of flags"); // [RULE25]

    property p_wrap;
        s_wrap |=> (st.cnt == 16'h0000) && st.flags[`CCA_FLAG_MAIN];
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter wrap wrong"); // [RULE23]

    property p_cycle;
        carry_n |=> st.flags[`CCA_FLAG_CYCLE];
    endproperty
    a_cycle: assert property (p_cycle) else $error("cycle flag missed"); // [RULE3]

    property p_timer;
        (kind_of(st.ch[1].mode) == CK_TIMER) && st.ch[1].mode.comp
            && st.ch[1].mode.mflag && eq16[1] |=> st.flags[1];
    endproperty
    a_timer: assert property (p_timer) else $error("timer match flag missed"); // [RULE21]

    property p_capture;
        (kind_of(st.ch[0].mode) == CK_CAPTURE) && edge_hit[0] && !wr_now
            |=> (st.ch[0].cmp == $past(st.cnt)) && st.flags[0];
    endproperty
    a_capture: assert property (p_capture) else $error("capture wrong"); // [RULE16]

    property p_low_clears;
        s_low_write |=> !st.ch[1].mode.comp;
    endproperty
    a_low_clears: assert property (p_low_clears) else $error("low write kept comp"); // [RULE22]

    property p_high_sets;
        s_high_write |=> st.ch[1].mode.comp;
    endproperty
    a_high_sets: assert property (p_high_sets) else $error("high write no comp"); // [RULE22]

    property p_pwm_off;
        (st.ch[2].mode.pulse && !st.ch[2].mode.toggle && !st.ch[2].mode.comp
            && !wr_now) |=> !CHANNEL_PIN_OUT[2];
    endproperty
    a_pwm_off: assert property (p_pwm_off) else $error("pwm off not low"); // [RULE12]

    property p_sticky;
        st.flags[0] && !(wr_now && (PADDR == `CCA_FLAGS_ADDR) && PWDATA[0])
            |=> st.flags[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost"); // [RULE18]

endmodule

// File: testbench/pin_source.sv
`timescale 1ns/1ps
// external pin driver and processor-side interrupt gate
module pin_source (
    // clock
    input  wire logic       clk,
    // processor enables and request
    input  wire logic       global_irq_en,
    input  wire logic       array_irq_en,
    input  wire logic       irq,
    output logic            irq_seen,
    // channel pins
    output logic      [5:0] pins
);
    initial pins = 6'h00;
    assign irq_seen = irq & global_irq_en & array_irq_en;
    task automatic drive(input int ch, input logic lvl);
        @(posedge clk);
        pins[ch] <= lvl;
        repeat (3) @(posedge clk);
    endtask
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
`include "counter_array_regs.svh"
module tb;
    import counter_array_pkg::*;
    logic        clk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  pin_in;
    logic [5:0]  pin_out;
    logic [5:0]  pin_oe;
    logic        irq;
    logic        irq_seen;
    logic        gen;
    logic        aen;
    logic [31:0] rdv;
    logic        erv;
    logic [15:0] v;
    int          err_total;
    int          n_tests;
    int          hi;
    int          i;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    counter_array_capture_compare dut (
        .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CHANNEL_PIN_IN(pin_in), .CHANNEL_PIN_OUT(pin_out),
        .CHANNEL_PIN_OE(pin_oe), .IRQ(irq)
    );

    pin_source src (
        .clk(clk), .global_irq_en(gen), .array_irq_en(aen), .irq(irq),
        .irq_seen(irq_seen), .pins(pin_in)
    );

    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic results();
        if (err_total == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) chk("pready", 1, pready);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string n);
        xfer(1'b0, a, 32'h0);
        chk(n, e, rdv & m);
    endtask

    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask

    task automatic run_cnt(input int n);
        wr(`CCA_CTRL_ADDR, 32'h1);
        hi = 0;
        repeat (n) begin
            @(posedge clk);
            hi += (pin_out[2] === 1'b1) ? 1 : 0;
        end
        wr(`CCA_CTRL_ADDR, 32'h0);
    endtask

    function automatic logic [7:0] cha(input int ch, input int sub);
        return 8'(32'h20 + ch * 16 + sub * 4);
    endfunction

    initial begin
        #300_000;
        err_total++;
        results();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {arst_n, gen, aen, err_total, n_tests} = '0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        for (i = 0; i < 10; i++) begin
            rdc((i < 4) ? 8'(i * 4) : cha(i - 4, 0), '1, 32'h0, "reset_val");
        end
        xfer(1'b0, 8'h10, 32'h0);
        chk("slverr", 1, {31'h0, erv});
        chk("unmapped", 0, rdv);
        // counter wrap with main enable off, then on
        wr(`CCA_COUNT_ADDR, 32'hFFF8);
        run_cnt(20);
        rdc(`CCA_FLAGS_ADDR, 32'hFF, 32'hC0, "wrap_flags");
        rdc(`CCA_COUNT_ADDR, 32'hFFC0, 32'h0, "wrap_count");
        irq_is(1'b0);
        wr(`CCA_CTRL_ADDR, 32'h2);
        irq_is(1'b1);
        gen <= 1'b1;
        aen <= 1'b1;
        @(posedge clk);
        chk("cpu_irq", 1, {31'h0, irq_seen});
        rdc(`CCA_FLAGS_ADDR, 32'hFF, 32'hC0, "sticky");
        wr(`CCA_FLAGS_ADDR, 32'hFF);
        irq_is(1'b0);
        wr(`CCA_CTRL_ADDR, 32'h0);
        // cycle overflow per length select
        for (i = 0; i < 4; i++) begin
            wr(`CCA_PWMCFG_ADDR, 32'(i) | ((i % 2 == 0) ? 32'h40 : 32'h0));
            wr(`CCA_COUNT_ADDR, 32'h00F8);
            run_cnt(10);
            rdc(`CCA_FLAGS_ADDR, 32'hC0, (i == 0) ? 32'h80 : 32'h0, "cyc_b8");
            wr(`CCA_FLAGS_ADDR, 32'hFF);
            wr(`CCA_COUNT_ADDR, (32'h100 << i) - 32'h8);
            run_cnt(10);
            rdc(`CCA_FLAGS_ADDR, 32'hC0, 32'h80, "cyc_bn");
            irq_is(i % 2 == 0);
            wr(`CCA_FLAGS_ADDR, 32'hFF);
        end
        wr(`CCA_PWMCFG_ADDR, 32'h0);
        // capture on every channel, counter stopped
        for (i = 0; i < 6; i++) begin
            v = 16'(32'h0F1E + i * 32'h0123);
            wr(`CCA_COUNT_ADDR, {16'h0, v});
            if (i % 2) src.drive(i, 1'b1);
            wr(cha(i, 0), (i % 2) ? 32'h11 : 32'h21);
            src.drive(i, (i % 2) ? 1'b0 : 1'b1);
            rdc(cha(i, 1), 32'hFF, {24'h0, v[7:0]}, "cap_low");
            rdc(cha(i, 2), 32'hFF, {24'h0, v[15:8]}, "cap_high");
            rdc(`CCA_FLAGS_ADDR, 32'h3F, 32'h1 << i, "cap_flag");
            irq_is(1'b1);
            wr(`CCA_COUNT_ADDR, 32'hABCD);
            src.drive(i, (i % 2) ? 1'b1 : 1'b0);
            rdc(cha(i, 1), 32'hFF, {24'h0, v[7:0]}, "wrong_edge");
            wr(`CCA_FLAGS_ADDR, 32'h1 << i);
            irq_is(1'b0);
        end
        wr(cha(0, 0), 32'h31);
        src.drive(0, 1'b1);
        rdc(`CCA_FLAGS_ADDR, 32'h101, 32'h101, "both_edge");
        wr(`CCA_FLAGS_ADDR, 32'h01);
        // software timer on channel 1
        wr(cha(1, 0), 32'h09);
        wr(cha(1, 1), 32'h40);
        rdc(cha(1, 0), 32'hFF, 32'h09, "low_clr");
        wr(cha(1, 2), 32'h00);
        rdc(cha(1, 0), 32'hFF, 32'h49, "high_set");
        wr(`CCA_COUNT_ADDR, 32'h41);
        run_cnt(20);
        rdc(`CCA_FLAGS_ADDR, 32'h2, 32'h0, "no_match");
        wr(`CCA_COUNT_ADDR, 32'h30);
        run_cnt(30);
        rdc(`CCA_FLAGS_ADDR, 32'h2, 32'h2, "match");
        irq_is(1'b1);
        wr(`CCA_FLAGS_ADDR, 32'h2);
        wr(cha(1, 0), 32'h0);
        // pulse modes on channel 2
        wr(cha(2, 0), 32'h02);
        wr(`CCA_COUNT_ADDR, 32'h0);
        run_cnt(300);
        chk("pwm_off", 0, hi);
        chk("pwm_oe", 1, {31'h0, pin_oe[2]});
        wr(cha(2, 1), 32'h80);
        wr(cha(2, 2), 32'h80);
        run_cnt(300);
        chk("pwm8", 1, {31'h0, hi > 100 && hi < 200});
        wr(`CCA_PWMCFG_ADDR, 32'h3);
        wr(cha(2, 0), 32'hC2);
        wr(cha(2, 1), 32'h00);
        wr(cha(2, 2), 32'hFF);
        wr(`CCA_COUNT_ADDR, 32'h0EF0);
        run_cnt(300);
        chk("pwm16", 0, hi);
        wr(cha(2, 0), 32'h0);
        // toggle output on channel 4, frequency output on channel 5
        wr(cha(4, 0), 32'h4C);
        wr(cha(4, 1), 32'h10);
        wr(cha(4, 2), 32'h00);
        wr(cha(5, 0), 32'h46);
        wr(cha(5, 1), 32'h08);
        wr(cha(5, 2), 32'h04);
        wr(`CCA_COUNT_ADDR, 32'h0);
        run_cnt(30);
        chk("hso_pin", 1, {31'h0, pin_out[4]});
        rdc(`CCA_FLAGS_ADDR, 32'h30, 32'h10, "hso_flag");
        chk("freq_oe", 1, {31'h0, pin_oe[5]});
        wr(`CCA_FLAGS_ADDR, 32'hFF);
        wr(cha(4, 0), 32'h0);
        wr(cha(5, 0), 32'h0);
        // reload view on channel 3
        wr(`CCA_PWMCFG_ADDR, 32'h01);
        wr(cha(3, 0), 32'h42);
        wr(cha(3, 1), 32'h11);
        wr(cha(3, 2), 32'h00);
        wr(`CCA_PWMCFG_ADDR, 32'h81);
        wr(cha(3, 1), 32'h22);
        wr(cha(3, 2), 32'h01);
        rdc(cha(3, 1), 32'hFF, 32'h22, "rld_low");
        rdc(cha(3, 2), 32'hFF, 32'h01, "rld_high");
        wr(`CCA_PWMCFG_ADDR, 32'h01);
        rdc(cha(3, 1), 32'hFF, 32'h11, "cmp_low");
        results();
    end
endmodule
